//--- processor_identification_responder.sv
// Summary of operation
// - Opcode bytes 0f a2 run the query; results land in words a to d.
// - The value in word a at start picks which leaf is returned.
// - Leaf 0 returns the highest selector, 2, in word a.
// - Leaf 0 returns the twelve-character vendor string across b, d, c.
// - Leaf 1 returns version in a, features in d; b and c reserved.
// - Leaf 2 returns cache and translation-buffer data in all four words.
// - Runs at any privilege level and waits for earlier work to finish.
// - Version word holds family, model, stepping and processor type.
// - Type codes: 00 original, 01 upgrade, 10 dual; 11 reserved.
// - A feature bit is 1 when supported, 0 when not.
// - Feature bit 0: on-chip floating-point unit present.
// - Feature bit 1: virtual-8086 mode enhancements supported.
// - Feature bit 2: debug extensions and I/O breakpoints supported.
// - Feature bit 3: 4-Mbyte pages supported.
// - Feature bit 4: cycle stamp counter read supported.
// - Feature bit 5: model register read and write supported.
// - Feature bit 6: wide physical addresses, 36 bits when enabled.
// - Leaf 2 low byte of word a gives the repeat count, 1.
// - Leaf 2 bit 31 of each word: 0 valid, 1 reserved.
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "ident_regs.svh"

module processor_identification_responder #(
   // Vendor text is arbitrary, twelve characters, first in the low byte
   parameter logic [95:0] VENDOR_STR      = {"0rdn", "Velp", "maxE"},
   // Family and model codes are arbitrary
   parameter logic [3:0]  FAMILY_ID       = 4'h3,
   parameter logic [3:0]  MODEL_ID        = 4'h5,
   parameter logic [6:0]  FEATURE_SUPPORT = 7'h7f,
   parameter logic [23:0] CACHE_A_HI      = 24'h0,
   parameter logic [30:0] CACHE_B         = 31'h0,
   parameter logic [30:0] CACHE_C         = 31'h0,
   parameter logic [30:0] CACHE_D         = 31'h0,
   parameter logic [3:0]  CACHE_VALID     = 4'hf,
   parameter int          ADDR_W          = 8
) (
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   input  wire logic              issue_valid,
   input  wire logic [7:0]        opcode_byte0,
   input  wire logic [7:0]        opcode_byte1,
   input  wire ident_pkg::word_type result_word_a_in,
   input  wire logic              older_pending,
   output logic                   fetch_hold,
   output logic                   result_valid,
   output ident_pkg::word_type    result_word_a,
   output ident_pkg::word_type    result_word_b,
   output ident_pkg::word_type    result_word_c,
   output ident_pkg::word_type    result_word_d,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_write,
   input  wire logic              reg_read,
   output logic [31:0]            reg_rdata
);
   import ident_pkg::*;

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   generate
      if (ADDR_W < 8) begin : g_bad_addr
         $error("reg_addr must be at least 8 bits wide");
      end
      if (CACHE_A_HI[23] != 1'b0) begin : g_bad_cache
         $error("CACHE_A_HI bit 23 is the reserved marker and must be zero");
      end
   endgenerate

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rst_meta_q;
   logic rst_sync_q;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   wire rst_sync_n = rst_sync_q;

   // ----------------------------------------------------------------
   // Register port decode
   // ----------------------------------------------------------------
   logic [3:0]  step_q;
   logic [1:0]  type_q;
   logic [6:0]  feat_mask_q;
   logic [31:0] count_q;
   logic [31:0] count_d;
   word_type    last_sel_q;
   logic [31:0] rd_data_q;

   wire [7:0] addr_lo      = reg_addr[7:0];
   wire       addr_hi_zero = (reg_addr >> 8) == '0;
   wire       hit_version  = addr_hi_zero && (addr_lo == `REG_VERSION);
   wire       hit_feature  = addr_hi_zero && (addr_lo == `REG_FEATURE);
   wire       hit_status   = addr_hi_zero && (addr_lo == `REG_STATUS);
   wire       hit_count    = addr_hi_zero && (addr_lo == `REG_COUNT);
   wire       hit_last_sel = addr_hi_zero && (addr_lo == `REG_LAST_SEL);

   wire       wr_version = reg_write && hit_version;
   wire       wr_feature = reg_write && hit_feature;
   wire       wr_count   = reg_write && hit_count;

   wire [3:0] new_step = reg_wdata[`RV_STEP_LSB +: 4];
   wire [1:0] new_type = reg_wdata[`RV_TYPE_LSB +: 2];
   // The reserved type code is never accepted; the old type stays
   wire       type_ok  = new_type != `TYPE_RSVD;

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         step_q <= `RST_STEP;
         type_q <= `RST_TYPE;
      end else if (wr_version) begin
         step_q <= new_step;
         if (type_ok) begin
            type_q <= new_type;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         feat_mask_q <= `RST_FEATURE_MASK;
      end else if (wr_feature) begin
         feat_mask_q <= reg_wdata[`FEAT_COUNT-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Instruction decode
   // ----------------------------------------------------------------
   ident_state_type state_q;
   ident_state_type state_d;
   word_type        sel_q;

   // Privilege level plays no part: the query is never refused
   wire is_ident = (opcode_byte0 == `OPC_ESCAPE) &&
                   (opcode_byte1 == `OPC_IDENT);
   wire idle     = state_q == ST_IDLE;
   // A second issue while busy cannot arrive since fetch is held
   wire accept   = issue_valid && is_ident && idle;
   wire drained  = !older_pending;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (accept) begin
               state_d = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            // Earlier updates must be complete before results are made
            if (drained) begin
               state_d = ST_LOOKUP;
            end
         end
         ST_LOOKUP: begin
            state_d = ST_DONE;
         end
         ST_DONE: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Selector is frozen at the start so later writes to word a do not leak in
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         sel_q <= 32'h0;
      end else if (accept) begin
         sel_q <= result_word_a_in;
      end
   end

   // ----------------------------------------------------------------
   // Leaf table
   // ----------------------------------------------------------------
   leaf_if lf ();

   assign lf.selector     = sel_q;
   assign lf.stepping     = step_q;
   assign lf.proc_type    = type_q;
   assign lf.feature_mask = feat_mask_q;

   ident_leaf_table #(
      .VENDOR_STR      (VENDOR_STR),
      .FAMILY_ID       (FAMILY_ID),
      .MODEL_ID        (MODEL_ID),
      .FEATURE_SUPPORT (FEATURE_SUPPORT),
      .CACHE_A_HI      (CACHE_A_HI),
      .CACHE_B         (CACHE_B),
      .CACHE_C         (CACHE_C),
      .CACHE_D         (CACHE_D),
      .CACHE_VALID     (CACHE_VALID)
   ) u_table (
      .lf (lf)
   );

   // ----------------------------------------------------------------
   // Result words and handshake
   // ----------------------------------------------------------------
   result_set_type res_q;
   logic           valid_q;
   logic           hold_q;

   wire capture = state_q == ST_LOOKUP;
   wire finish  = state_q == ST_DONE;

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         res_q <= '{a: 32'h0, b: 32'h0, c: 32'h0, d: 32'h0};
      end else if (capture) begin
         res_q <= lf.result;
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         valid_q <= 1'b0;
      end else begin
         valid_q <= capture;
      end
   end

   // Fetch stays held from acceptance until results have been handed over
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         hold_q <= 1'b0;
      end else if (accept) begin
         hold_q <= 1'b1;
      end else if (finish) begin
         hold_q <= 1'b0;
      end
   end

   assign fetch_hold    = hold_q;
   assign result_valid  = valid_q;
   assign result_word_a = res_q.a;
   assign result_word_b = res_q.b;
   assign result_word_c = res_q.c;
   assign result_word_d = res_q.d;

   // ----------------------------------------------------------------
   // Query statistics
   // ----------------------------------------------------------------
   // A completion in the same cycle as a clear still counts
   assign count_d = wr_count ? (capture ? 32'h1 : 32'h0)
                             : (capture ? count_q + 32'h1 : count_q);

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         count_q <= 32'h0;
      end else begin
         count_q <= count_d;
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         last_sel_q <= 32'h0;
      end else if (capture) begin
         last_sel_q <= sel_q;
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   wire [31:0] version_rd = (32'(step_q) << `RV_STEP_LSB) |
                            (32'(type_q) << `RV_TYPE_LSB);
   wire [31:0] feature_rd = 32'(feat_mask_q);
   wire [31:0] status_rd  = (32'(!idle)                 << `ST_BUSY_BIT) |
                            (32'(hold_q)                << `ST_HOLD_BIT) |
                            (32'(state_q == ST_DRAIN)   << `ST_WAIT_BIT);
   wire [31:0] rd_mux     = hit_version  ? version_rd :
                            hit_feature  ? feature_rd :
                            hit_status   ? status_rd  :
                            hit_count    ? count_q    :
                            hit_last_sel ? last_sel_q : 32'h0;

   // Data stand only in the cycle after the read strobe
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rd_data_q <= 32'h0;
      end else if (reg_read) begin
         rd_data_q <= rd_mux;
      end else begin
         rd_data_q <= 32'h0;
      end
   end

   assign reg_rdata = rd_data_q;

endmodule : processor_identification_responder

//--- ident_regs.svh
`ifndef IDENT_REGS_SVH
`define IDENT_REGS_SVH

// ----------------------------------------------------------------
// Instruction encoding
// ----------------------------------------------------------------
`define OPC_ESCAPE        8'h0f
`define OPC_IDENT         8'ha2

// ----------------------------------------------------------------
// Selector values
// ----------------------------------------------------------------
`define LEAF_BASIC        32'h0000_0000
`define LEAF_VERSION      32'h0000_0001
`define LEAF_CACHE        32'h0000_0002
`define LEAF_MAX          32'h0000_0002

// ----------------------------------------------------------------
// Version word layout and processor type codes
// ----------------------------------------------------------------
`define VER_STEP_LSB      0
`define VER_MODEL_LSB     4
`define VER_FAMILY_LSB    8
`define VER_TYPE_LSB      12
`define TYPE_OEM          2'h0
`define TYPE_UPGRADE      2'h1
`define TYPE_DUAL         2'h2
`define TYPE_RSVD         2'h3

// ----------------------------------------------------------------
// Feature flag positions
// ----------------------------------------------------------------
`define FEAT_FLOAT        0
`define FEAT_VIRT_MODE    1
`define FEAT_DEBUG        2
`define FEAT_LARGE_PAGE   3
`define FEAT_STAMP        4
`define FEAT_MODEL_REG    5
`define FEAT_WIDE_PHYS    6
`define FEAT_COUNT        7

// ----------------------------------------------------------------
// Cache leaf
// ----------------------------------------------------------------
`define CACHE_REPEAT      8'h01
`define CACHE_RSVD_BIT    31

// ----------------------------------------------------------------
// Register offsets, field positions and reset values
// ----------------------------------------------------------------
`define REG_VERSION       8'h00
`define REG_FEATURE       8'h04
`define REG_STATUS        8'h08
`define REG_COUNT         8'h0c
`define REG_LAST_SEL      8'h10
`define RV_STEP_LSB       0
`define RV_TYPE_LSB       4
`define ST_BUSY_BIT       0
`define ST_HOLD_BIT       1
`define ST_WAIT_BIT       2
`define RST_STEP          4'h0
`define RST_TYPE          2'h0
`define RST_FEATURE_MASK  7'h7f

`endif

//--- ident_pkg.sv
package ident_pkg;

   typedef logic [31:0] word_type;

   typedef enum {
      ST_IDLE,
      ST_DRAIN,
      ST_LOOKUP,
      ST_DONE
   } ident_state_type;

   typedef struct packed {
      word_type a;
      word_type b;
      word_type c;
      word_type d;
   } result_set_type;

endpackage : ident_pkg

//--- leaf_if.sv
`timescale 1ns/1ps

interface leaf_if;
   import ident_pkg::*;

   word_type       selector;
   logic [3:0]     stepping;
   logic [1:0]     proc_type;
   logic [6:0]     feature_mask;
   result_set_type result;

   modport table_side (
      input  selector,
      input  stepping,
      input  proc_type,
      input  feature_mask,
      output result
   );

   modport core_side (
      output selector,
      output stepping,
      output proc_type,
      output feature_mask,
      input  result
   );
endinterface : leaf_if

//--- ident_leaf_table.sv
`timescale 1ns/1ps
`include "ident_regs.svh"

module ident_leaf_table #(
   parameter logic [95:0] VENDOR_STR      = 96'h0,
   parameter logic [3:0]  FAMILY_ID       = 4'h0,
   parameter logic [3:0]  MODEL_ID        = 4'h0,
   parameter logic [6:0]  FEATURE_SUPPORT = 7'h7f,
   parameter logic [23:0] CACHE_A_HI      = 24'h0,
   parameter logic [30:0] CACHE_B         = 31'h0,
   parameter logic [30:0] CACHE_C         = 31'h0,
   parameter logic [30:0] CACHE_D         = 31'h0,
   parameter logic [3:0]  CACHE_VALID     = 4'hf
) (
   leaf_if.table_side lf
);
   import ident_pkg::*;

   // ----------------------------------------------------------------
   // Leaf words
   // ----------------------------------------------------------------
   word_type       version_word;
   word_type       feature_word;
   word_type       cache_a;
   word_type       cache_b;
   word_type       cache_c;
   word_type       cache_d;
   result_set_type basic_set;
   result_set_type version_set;
   result_set_type cache_set;
   result_set_type zero_set;

   assign version_word = (32'(lf.stepping)  << `VER_STEP_LSB)   |
                         (32'(MODEL_ID)     << `VER_MODEL_LSB)  |
                         (32'(FAMILY_ID)    << `VER_FAMILY_LSB) |
                         (32'(lf.proc_type) << `VER_TYPE_LSB);
   // Bits above the defined features stay zero
   assign feature_word = 32'(FEATURE_SUPPORT &
                             lf.feature_mask);

   // First vendor character sits in the low byte of word b
   assign basic_set   = '{a: `LEAF_MAX,
                          b: VENDOR_STR[31:0],
                          c: VENDOR_STR[95:64],
                          d: VENDOR_STR[63:32]};
   assign version_set = '{a: version_word, b: 32'h0, c: 32'h0,
                          d: feature_word};

   // A reserved cache word carries only its marker bit; a reserved word a also keeps the repeat count
   assign cache_a = CACHE_VALID[0] ? {1'b0, CACHE_A_HI[22:0], `CACHE_REPEAT}
                                   : {1'b1, 23'h0, `CACHE_REPEAT};
   assign cache_b = CACHE_VALID[1] ? {1'b0, CACHE_B} : 32'h8000_0000;
   assign cache_c = CACHE_VALID[2] ? {1'b0, CACHE_C} : 32'h8000_0000;
   assign cache_d = CACHE_VALID[3] ? {1'b0, CACHE_D} : 32'h8000_0000;
   assign cache_set = '{a: cache_a, b: cache_b, c: cache_c, d: cache_d};
   assign zero_set  = '{a: 32'h0, b: 32'h0, c: 32'h0, d: 32'h0};

   // Selectors above the highest one read as all zero
   assign lf.result = (lf.selector == `LEAF_BASIC)   ? basic_set   :
                      (lf.selector == `LEAF_VERSION) ? version_set :
                      (lf.selector == `LEAF_CACHE)   ? cache_set   : zero_set;

endmodule : ident_leaf_table

//--- ident_responder_properties.sv
`timescale 1ns/1ps
module ident_responder_checker #(
   parameter int ADDR_W = 8
) (
   input wire logic                core_clk,
   input wire logic                rst_n,
   input wire logic                issue_valid,
   input wire logic [7:0]          opcode_byte0,
   input wire logic [7:0]          opcode_byte1,
   input wire ident_pkg::word_type result_word_a_in,
   input wire logic                older_pending,
   input wire logic                fetch_hold,
   input wire logic                result_valid,
   input wire ident_pkg::word_type result_word_a,
   input wire ident_pkg::word_type result_word_b,
   input wire ident_pkg::word_type result_word_c,
   input wire ident_pkg::word_type result_word_d,
   input wire logic [ADDR_W-1:0]   reg_addr,
   input wire logic [31:0]         reg_wdata,
   input wire logic                reg_write,
   input wire logic                reg_read,
   input wire logic [31:0]         reg_rdata
);
   import ident_pkg::*;
   // ----------------------------------------
   // Helper logic
   // ----------------------------------------
   word_type sel_q;
   wire      take_w = issue_valid && opcode_byte0 == 8'h0f && opcode_byte1 == 8'ha2
                      && !fetch_hold && !result_valid;
   wire      hole_w = !(reg_addr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10});
   // Remembers the selector so each answer can be judged against its leaf
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) sel_q <= 32'h0;
      else if (take_w) sel_q <= result_word_a_in;
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_take; take_w; endsequence
   sequence s_fast_take; take_w && !older_pending ##1 !older_pending [*2]; endsequence
   property p_fast; s_fast_take |=> result_valid; endproperty
   property p_bound; s_take |=> !result_valid ##1 !result_valid ##[1:40] result_valid; endproperty
   property p_hold_set; s_take |=> fetch_hold; endproperty
   property p_hold_keep; fetch_hold && !result_valid |=> fetch_hold; endproperty
   property p_release; result_valid |-> fetch_hold ##1 (!fetch_hold && !result_valid); endproperty
   property p_words; !result_valid |-> $stable({result_word_a, result_word_b,
                                                result_word_c, result_word_d}); endproperty
   property p_leaf0; result_valid && sel_q == 32'h0 |-> result_word_a == 32'h2; endproperty
   property p_leaf1; result_valid && sel_q == 32'h1 |-> result_word_b == 32'h0
      && result_word_c == 32'h0 && result_word_d[31:7] == 25'h0; endproperty
   property p_leaf2; result_valid && sel_q == 32'h2 |-> result_word_a[7:0] == 8'h01; endproperty
   property p_high; result_valid && sel_q > 32'h2 |-> {result_word_a, result_word_b,
      result_word_c, result_word_d} == 128'h0; endproperty
   property p_bad_op; issue_valid && !take_w && !fetch_hold && !result_valid
      |=> !fetch_hold; endproperty
   property p_rd_idle; $past(reg_read) == 1'b0 |-> reg_rdata == 32'h0; endproperty
   property p_hole; reg_read && hole_w |=> reg_rdata == 32'h0; endproperty
   a_fast: assert property (p_fast) else $error("answer late after quiet issue");
   a_bound: assert property (p_bound) else $error("answer timing wrong");
   a_hold_set: assert property (p_hold_set) else $error("fetch hold not raised");
   a_hold_keep: assert property (p_hold_keep) else $error("fetch hold dropped early");
   a_release: assert property (p_release) else $error("hold or valid not released");
   a_words: assert property (p_words) else $error("result words moved");
   a_leaf0: assert property (p_leaf0) else $error("leaf 0 max selector");
   a_leaf1: assert property (p_leaf1) else $error("leaf 1 reserved bits");
   a_leaf2: assert property (p_leaf2) else $error("leaf 2 repeat count");
   a_high: assert property (p_high) else $error("high selector not zero");
   a_bad_op: assert property (p_bad_op) else $error("foreign opcode taken");
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
   a_hole: assert property (p_hole) else $error("unmapped read not zero");
endmodule : ident_responder_checker

bind processor_identification_responder ident_responder_checker #(.ADDR_W(ADDR_W)) u_chk (
   .core_clk(core_clk), .rst_n(rst_n), .issue_valid(issue_valid),
   .opcode_byte0(opcode_byte0), .opcode_byte1(opcode_byte1),
   .result_word_a_in(result_word_a_in), .older_pending(older_pending),
   .fetch_hold(fetch_hold), .result_valid(result_valid), .result_word_a(result_word_a),
   .result_word_b(result_word_b), .result_word_c(result_word_c),
   .result_word_d(result_word_d), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import ident_pkg::*;
   // Vendor text is arbitrary
   localparam logic [95:0] VS  = {"ip42", "Corp", "Test"};
   localparam logic [3:0]  FAM = 4'h3;
   localparam logic [3:0]  MDL = 4'h5;
   localparam logic [6:0]  SUP = 7'h5b;
   localparam logic [30:0] CC  = 31'h11;
   localparam logic [30:0] CD  = 31'h06040a42;
   logic core_clk, rst_n, issue_valid, older_pending, fetch_hold, result_valid;
   logic reg_write, reg_read, rd_flag;
   logic [7:0] opcode_byte0, opcode_byte1, reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   word_type result_word_a_in, result_word_a, result_word_b, result_word_c, result_word_d;
   result_set_type res_q[$];
   logic [31:0] rd_q[$];
   int err_total, check_count, cyc, seed;
   processor_identification_responder #(.VENDOR_STR(VS), .FAMILY_ID(FAM), .MODEL_ID(MDL),
      .FEATURE_SUPPORT(SUP), .CACHE_A_HI(24'h030201), .CACHE_B(31'h55), .CACHE_C(CC),
      .CACHE_D(CD), .CACHE_VALID(4'b1101), .ADDR_W(8)) DUT (
      .core_clk(core_clk), .rst_n(rst_n), .issue_valid(issue_valid),
      .opcode_byte0(opcode_byte0), .opcode_byte1(opcode_byte1),
      .result_word_a_in(result_word_a_in), .older_pending(older_pending),
      .fetch_hold(fetch_hold), .result_valid(result_valid), .result_word_a(result_word_a),
      .result_word_b(result_word_b), .result_word_c(result_word_c),
      .result_word_d(result_word_d), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
   // ----------------------------------------
   // Clock, checks and closing
   // ----------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task report_and_stop;
      if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   // Whole run needs well under a thousand cycles
   always @(posedge core_clk) begin
      cyc++;
      if (cyc >= 2000) begin
         err_total++;
         report_and_stop;
      end
   end
   // Outputs are judged at the falling edge, clear of the launching edge
   always @(negedge core_clk) begin : mon
      result_set_type er;
      if (result_valid === 1'b1) begin
         if (res_q.size() == 0) chk("unexpected result", 32'h0, 32'h1);
         else begin
            er = res_q.pop_front();
            chk("word a", er.a, result_word_a);
            chk("word b", er.b, result_word_b);
            chk("word c", er.c, result_word_c);
            chk("word d", er.d, result_word_d);
         end
      end
      if (rd_flag) chk("read data", rd_q.pop_front(), reg_rdata);
      rd_flag = (reg_read === 1'b1);
   end
   // ----------------------------------------
   // Drivers
   // ----------------------------------------
   task reg_wr(input logic [7:0] addr, input logic [31:0] data);
      @(posedge core_clk);
      reg_addr <= addr;
      reg_wdata <= data;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask : reg_wr
   task reg_rd(input logic [7:0] addr, input logic [31:0] exp);
      @(posedge core_clk);
      reg_addr <= addr;
      reg_read <= 1'b1;
      rd_q.push_back(exp);
      @(posedge core_clk);
      reg_read <= 1'b0;
   endtask : reg_rd
   // Older work stays pending for pend cycles, stretching the answer
   task query(input word_type s, input result_set_type e, input int pend);
      int n;
      @(posedge core_clk);
      issue_valid <= 1'b1;
      result_word_a_in <= s;
      older_pending <= (pend > 0);
      res_q.push_back(e);
      @(posedge core_clk);
      issue_valid <= 1'b0;
      result_word_a_in <= $random(seed);
      repeat (pend) @(posedge core_clk);
      older_pending <= 1'b0;
      n = 0;
      while (result_valid !== 1'b1 && n < 60) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 60) chk("answer wait", 32'h0, 32'h1);
      @(posedge core_clk);
   endtask : query
   function automatic result_set_type leaf1(logic [1:0] ty, logic [3:0] st, logic [6:0] m);
      result_set_type r;
      r = '0;
      r.a = {18'h0, ty, FAM, MDL, st};
      r.d = {25'h0, SUP & m};
      return r;
   endfunction : leaf1
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin : main
      logic [3:0] st;
      logic [1:0] ty, cur_ty;
      logic [6:0] m;
      word_type s;
      {rst_n, issue_valid, older_pending, reg_write, reg_read, rd_flag} = '0;
      {reg_addr, reg_wdata, result_word_a_in} = '0;
      {opcode_byte0, opcode_byte1} = 16'h0fa2;
      {err_total, check_count, cyc} = '0;
      seed = 76;
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      reg_rd(8'h00, 32'h0);
      reg_rd(8'h04, 32'h7f);
      reg_rd(8'h20, 32'h0);
      query(32'h0, '{a: 32'h2, b: VS[31:0], c: VS[95:64], d: VS[63:32]}, 0);
      cur_ty = 2'h0;
      st = 4'h0;
      for (int i = 0; i < 8; i++) begin
         st = 4'($random(seed));
         ty = i[1:0];
         m = 7'(1 << i);
         reg_wr(8'h00, {26'h0, ty, st});
         // Reserved type code must leave the previous type in place
         if (ty != 2'h3) cur_ty = ty;
         reg_wr(8'h04, {25'h0, m});
         reg_rd(8'h00, {26'h0, cur_ty, st});
         query(32'h1, leaf1(cur_ty, st, m), i);
      end
      query(32'h2, {32'h03020101, 32'h80000000, 1'b0, CC, 1'b0, CD}, 2);
      repeat (4) begin
         s = $random(seed);
         if (s < 32'h3) s = s + 32'h3;
         query(s, '0, 0);
      end
      @(posedge core_clk);
      issue_valid <= 1'b1;
      opcode_byte1 <= 8'ha3;
      @(posedge core_clk);
      issue_valid <= 1'b0;
      opcode_byte1 <= 8'ha2;
      repeat (3) @(negedge core_clk);
      chk("hold after foreign opcode", 32'h0, {31'h0, fetch_hold});
      reg_rd(8'h0c, 32'd14);
      reg_rd(8'h10, s);
      reg_rd(8'h08, 32'h0);
      reg_wr(8'h0c, 32'h0);
      reg_wr(8'h24, 32'hffffffff);
      reg_rd(8'h0c, 32'h0);
      reg_rd(8'h00, {26'h0, cur_ty, st});
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      reg_rd(8'h04, 32'h7f);
      repeat (4) @(posedge core_clk);
      report_and_stop;
   end
endmodule : tb_top
